// >>> logic/ttc_pkg.sv
package ttc_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] TTC_OFS_GATE_CTRL = 4'h0;
  localparam logic [3:0] TTC_OFS_AUTO_CFG = 4'h1;
  localparam logic [3:0] TTC_OFS_LOAD_REQ = 4'h2;
  localparam logic [3:0] TTC_OFS_STATUS = 4'h3;
  localparam logic [3:0] TTC_OFS_EVENTS = 4'h4;
  localparam logic [3:0] TTC_OFS_OP_POINT = 4'h5;
  localparam logic [3:0] TTC_OFS_IDENT = 4'h6;

  // Clock-gating control field layout.
  localparam int TTC_GATE_ONDEMAND_BIT = 4;
  localparam int TTC_GATE_DUTY_LSB = 1;
  localparam int TTC_GATE_DUTY_W = 3;
  localparam logic [4:0] TTC_GATE_CTRL_RST = 5'h00;

  // Automatic configuration field layout.
  localparam int TTC_AUTO_EN_BIT = 0;
  localparam int TTC_AUTO_OPPT_BIT = 1;
  localparam int TTC_AUTO_INT_ASSERT_BIT = 2;
  localparam int TTC_AUTO_INT_DEASSERT_BIT = 3;
  localparam int TTC_AUTO_THERM_PT_LSB = 8;
  localparam logic [15:0] TTC_AUTO_CFG_RST = 16'h0001;

  localparam int TTC_OPPT_W = 8;
  localparam logic [7:0] TTC_OPPT_RST = 8'hFF;
  localparam logic [7:0] TTC_THERM_PT_RST = 8'h40;

  // Temperature thresholds in degrees C (8-bit sensed code).
  localparam logic [7:0] TTC_TRIP_TEMP = 8'h64;
  localparam logic [7:0] TTC_HYST = 8'h02;
  localparam logic [7:0] TTC_CAT_TEMP = 8'h7D;

  // Clock-gating slot length: base cycles at the lowest ratio, shrinking with ratio.
  localparam logic [15:0] TTC_GATE_BASE = 16'h0800;
  // Identification value is arbitrary.
  localparam logic [15:0] TTC_IDENT_RST = 16'h5A5A;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ttc_bus_req_t;

  typedef enum {
    TTC_IDLE,
    TTC_GATE_AUTO,
    TTC_OPPT_AUTO,
    TTC_GATE_DEMAND,
    TTC_SHUTDOWN
  } ttc_state_t;

endpackage : ttc_pkg

// >>> logic/ttc_gate_mod.sv
// Generates the core clock enable for clock gating: one period of 8 slots,
// with duty_in slots on, the period length scaled by the core ratio.
module ttc_gate_mod
  import ttc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [2:0] duty_in,
  input wire logic [7:0] ratio_in,
  output logic clk_on_out
);

  logic [15:0] slot_len;
  logic [15:0] cnt_reg;
  logic [2:0] slot_reg;
  logic on_reg;

  always_comb begin
    slot_len = (TTC_GATE_BASE / {8'h00, (ratio_in == 8'h00) ? 8'h01 : ratio_in});
    if (slot_len == 16'h0000) begin
      slot_len = 16'h0001;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 16'h0000;
      slot_reg <= 3'h0;
    end else if (!run_in) begin
      cnt_reg <= 16'h0000;
      slot_reg <= 3'h0;
    end else if (cnt_reg >= slot_len - 16'h0001) begin
      cnt_reg <= 16'h0000;
      slot_reg <= slot_reg + 3'h1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_reg <= 1'b1;
    end else begin
      on_reg <= !run_in || (slot_reg < duty_in);
    end
  end

  assign clk_on_out = on_reg;

endmodule : ttc_gate_mod

// >>> logic/ttc_throttle_top.sv
// Functional notes
// - Automatic mode overrides on-demand when both active.
// - Automatic engages only at trip temperature.
// - Software picks clock gating or operating-point variant.
// - Hot with operating-point variant lowers operating point.
// - Cooling restores last requested operating point.
// - Higher load request held pending during thermal event.
// - Lower load request applied immediately during thermal.
// - Automatic clock gating uses fixed 50% duty.
// - Gating period shrinks as core frequency rises.
// - Cooling stops gating and clears throttle active.
// - Trip comparison uses hysteresis.
// - On-demand bit engages gating regardless of temperature unless automatic mode is engaged.
// - Three-bit field sets on-demand on-time eighths.
// - Hot indicator asserted low above trip point.
// - Snooping and interrupt latching continue while throttled.
// - Optional interrupt on hot assert and deassert.
// - No new hot assertion in clock-stopped states.
// - Hot held through clock-stopped state until exit and cool.
// - Catastrophic trip near 125 C shuts down always.
// - Catastrophic trip independent of activity, no bus cycles.
module ttc_throttle_top
  import ttc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [7:0] die_temp_in,
  input wire logic clk_stopped_in,
  input wire logic [7:0] core_ratio_in,
  output logic [7:0] op_point_out,
  output logic core_clk_en_out,
  output logic throttle_active_out,
  output logic therm_irq_out,
  output logic die_hot_indicator_n_out,
  output logic catastrophic_trip_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  ttc_bus_req_t bus;
  logic [4:0] gate_ctrl_reg;
  logic [15:0] auto_cfg_reg;
  logic [7:0] load_req_reg;
  logic load_pend_reg;
  logic [7:0] op_point_reg;
  logic [7:0] op_point_next;
  logic [1:0] events_reg;
  logic [31:0] rdata_reg;
  logic hot_reg;
  logic cat_reg;
  logic shown_hot_reg;
  logic shown_hot_prev_reg;
  logic [7:0] temp_s1_reg;
  logic [7:0] temp_s2_reg;
  logic [7:0] temp_s3_reg;
  logic [7:0] temp_ok_reg;
  logic stop_s1_reg;
  logic stop_s2_reg;
  logic stop_s3_reg;
  logic stop_ok_reg;
  ttc_state_t state_reg;
  ttc_state_t state_next;
  logic gate_run;
  logic [2:0] gate_duty;
  logic gate_on;
  logic auto_en;
  logic auto_oppt;
  logic [7:0] therm_pt;
  logic ondemand;
  logic [2:0] demand_duty;
  logic ev_assert;
  logic ev_deassert;
  logic ev_clr_wr;
  logic [1:0] ev_edge;
  logic [1:0] ev_en;
  logic [1:0] events_next;

  assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  function automatic logic hit(input ttc_bus_req_t b, input logic [3:0] ofs);
    hit = (b.addr == ofs);
  endfunction : hit

  // Shutdown is not counted as throttling, so the output and the status agree.
  function automatic logic throttling(input ttc_state_t s);
    throttling = (s != TTC_IDLE) && (s != TTC_SHUTDOWN);
  endfunction : throttling

  assign auto_en = auto_cfg_reg[TTC_AUTO_EN_BIT];
  assign auto_oppt = auto_cfg_reg[TTC_AUTO_OPPT_BIT];
  assign therm_pt = auto_cfg_reg[TTC_AUTO_THERM_PT_LSB +: TTC_OPPT_W];
  assign ondemand = gate_ctrl_reg[TTC_GATE_ONDEMAND_BIT];
  assign demand_duty = gate_ctrl_reg[TTC_GATE_DUTY_LSB +: TTC_GATE_DUTY_W];

  ////////////////////////////////////////////////////////////////////////////
  // Pin-side inputs pass three flops; a change counts once stages 2 and 3 agree.
  // The temperature word is taken whole, so a code caught mid-change never counts.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      temp_s1_reg <= 8'h00;
      temp_s2_reg <= 8'h00;
      temp_s3_reg <= 8'h00;
      temp_ok_reg <= 8'h00;
    end else begin
      temp_s1_reg <= die_temp_in;
      temp_s2_reg <= temp_s1_reg;
      temp_s3_reg <= temp_s2_reg;
      if (temp_s2_reg == temp_s3_reg) begin
        temp_ok_reg <= temp_s3_reg;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      stop_s3_reg <= 1'b0;
      stop_ok_reg <= 1'b0;
    end else begin
      stop_s1_reg <= clk_stopped_in;
      stop_s2_reg <= stop_s1_reg;
      stop_s3_reg <= stop_s2_reg;
      if (stop_s2_reg == stop_s3_reg) begin
        stop_ok_reg <= stop_s3_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip detection with hysteresis and catastrophic latch.
  // Between the two thresholds the last decision stands, so a hovering reading cannot toggle it.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hot_reg <= 1'b0;
    end else if (temp_ok_reg >= TTC_TRIP_TEMP) begin
      hot_reg <= 1'b1;
    end else if (temp_ok_reg < TTC_TRIP_TEMP - TTC_HYST) begin
      hot_reg <= 1'b0;
    end
  end

  // Latches until reset; no register or bus access takes part.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cat_reg <= 1'b0;
    end else if (temp_ok_reg >= TTC_CAT_TEMP) begin
      cat_reg <= 1'b1;
    end
  end

  // Hot indicator: no new assertion while clocks stopped, held if already on.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shown_hot_reg <= 1'b0;
      shown_hot_prev_reg <= 1'b0;
    end else begin
      shown_hot_prev_reg <= shown_hot_reg;
      if (stop_ok_reg) begin
        shown_hot_reg <= shown_hot_reg;
      end else begin
        shown_hot_reg <= hot_reg;
      end
    end
  end

  assign ev_assert = shown_hot_reg && !shown_hot_prev_reg;
  assign ev_deassert = !shown_hot_reg && shown_hot_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Throttle state selection.
  // A catastrophic trip outranks automatic mode, which outranks on-demand gating.
  always_comb begin
    state_next = TTC_IDLE;
    if (cat_reg) begin
      state_next = TTC_SHUTDOWN;
    end else if (auto_en && hot_reg) begin
      state_next = auto_oppt ? TTC_OPPT_AUTO : TTC_GATE_AUTO;
    end else if (ondemand && demand_duty != 3'h0) begin
      state_next = TTC_GATE_DEMAND;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= TTC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    gate_run = 1'b0;
    gate_duty = 3'h4;
    case (state_reg)
      TTC_GATE_AUTO: begin
        gate_run = 1'b1;
        gate_duty = 3'h4;
      end
      TTC_GATE_DEMAND: begin
        gate_run = 1'b1;
        gate_duty = demand_duty;
      end
      default: begin
        gate_run = 1'b0;
        gate_duty = 3'h4;
      end
    endcase
  end

  // Period length follows the core ratio.
  ttc_gate_mod u_gate (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .run_in(gate_run),
    .duty_in(gate_duty),
    .ratio_in(core_ratio_in),
    .clk_on_out(gate_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operating-point arbitration between thermal and load requests.
  // While hot the lower of the two targets wins; a higher request waits for cooling.
  always_comb begin
    op_point_next = op_point_reg;
    if (state_reg == TTC_OPPT_AUTO) begin
      if (load_pend_reg && load_req_reg < therm_pt) begin
        op_point_next = load_req_reg;
      end else if (load_req_reg < therm_pt) begin
        op_point_next = load_req_reg;
      end else begin
        op_point_next = therm_pt;
      end
    end else begin
      op_point_next = load_req_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_point_reg <= TTC_OPPT_RST;
    end else begin
      op_point_reg <= op_point_next;
    end
  end

  // Pending flag marks a load request deferred behind the thermal target.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_pend_reg <= 1'b0;
    end else if (bus.wr && hit(bus, TTC_OFS_LOAD_REQ)) begin
      load_pend_reg <= (state_reg == TTC_OPPT_AUTO) && (bus.wdata[7:0] >= therm_pt);
    end else if (state_reg != TTC_OPPT_AUTO) begin
      load_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; bit 0 of the gating control has no function and reads zero.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_ctrl_reg <= TTC_GATE_CTRL_RST;
    end else if (bus.wr && hit(bus, TTC_OFS_GATE_CTRL)) begin
      gate_ctrl_reg <= {bus.wdata[4:1], 1'b0};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      auto_cfg_reg <= TTC_AUTO_CFG_RST;
    end else if (bus.wr && hit(bus, TTC_OFS_AUTO_CFG)) begin
      auto_cfg_reg <= {bus.wdata[15:8], 4'h0, bus.wdata[3:0]};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_req_reg <= TTC_OPPT_RST;
    end else if (bus.wr && hit(bus, TTC_OFS_LOAD_REQ)) begin
      load_req_reg <= bus.wdata[7:0];
    end
  end

  // Sticky hot-edge events, write one to clear; a new edge wins over the clear.
  assign ev_clr_wr = bus.wr && hit(bus, TTC_OFS_EVENTS);
  assign ev_edge = {ev_deassert, ev_assert};
  assign ev_en = {auto_cfg_reg[TTC_AUTO_INT_DEASSERT_BIT], auto_cfg_reg[TTC_AUTO_INT_ASSERT_BIT]};

  for (genvar i = 0; i < 2; i++) begin : g_event
    assign events_next[i] = (events_reg[i] && !(ev_clr_wr && bus.wdata[i])) || (ev_edge[i] && ev_en[i]);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      events_reg <= 2'b00;
    end else begin
      events_reg <= events_next;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus.rd) begin
      case (bus.addr)
        TTC_OFS_GATE_CTRL: rdata_reg <= {27'h000_0000, gate_ctrl_reg};
        TTC_OFS_AUTO_CFG: rdata_reg <= {16'h0000, auto_cfg_reg};
        TTC_OFS_LOAD_REQ: rdata_reg <= {24'h00_0000, load_req_reg};
        TTC_OFS_STATUS: rdata_reg <= {27'h000_0000, load_pend_reg, cat_reg, shown_hot_reg, hot_reg,
                                      throttling(state_reg)};
        TTC_OFS_EVENTS: rdata_reg <= {30'h0000_0000, events_reg};
        TTC_OFS_OP_POINT: rdata_reg <= {24'h00_0000, op_point_reg};
        TTC_OFS_IDENT: rdata_reg <= {16'h0000, TTC_IDENT_RST}; // Arbitrary value.
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating only stops core clocks; snoop and interrupt latch logic stay clocked.
  assign core_clk_en_out = gate_on && !cat_reg;
  assign throttle_active_out = throttling(state_reg);
  assign therm_irq_out = |events_reg;
  assign die_hot_indicator_n_out = !shown_hot_reg;
  assign catastrophic_trip_n_out = !cat_reg;
  assign op_point_out = op_point_reg;
  assign reg_rdata_out = rdata_reg;

endmodule : ttc_throttle_top

// >>> tb/ttc_throttle_monitor.sv
module ttc_mon
  import ttc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] die_temp_in,
  input wire logic clk_stopped_in,
  input wire logic core_clk_en_out,
  input wire logic throttle_active_out,
  input wire logic die_hot_indicator_n_out,
  input wire logic catastrophic_trip_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Eight steady samples cover the input synchroniser and its filter.
  sequence s_hot;
    (die_temp_in > 8'h66 && !clk_stopped_in && catastrophic_trip_n_out) [*8];
  endsequence
  sequence s_cool;
    (die_temp_in < 8'h60 && !clk_stopped_in && catastrophic_trip_n_out) [*8];
  endsequence
  sequence s_demand_wr;
    reg_wr_in && reg_addr_in == TTC_OFS_GATE_CTRL && reg_wdata_in[4] && reg_wdata_in[3:1] != 3'h0;
  endsequence
  property p_hot;
    s_hot |-> ##[0:6] !die_hot_indicator_n_out;
  endproperty
  a_hot: assert property (p_hot) else $error("hot indicator not shown");
  property p_cool;
    s_cool |-> ##[0:6] die_hot_indicator_n_out;
  endproperty
  a_cool: assert property (p_cool) else $error("hot indicator not released");
  property p_stop;
    clk_stopped_in [*8] |=> $stable(die_hot_indicator_n_out);
  endproperty
  a_stop: assert property (p_stop) else $error("hot changed while stopped");
  property p_idle;
    (!throttle_active_out && catastrophic_trip_n_out) [*3] |-> core_clk_en_out;
  endproperty
  a_idle: assert property (p_idle) else $error("clock gated while idle");
  property p_demand;
    s_demand_wr ##0 catastrophic_trip_n_out |-> ##[1:3] throttle_active_out;
  endproperty
  a_demand: assert property (p_demand) else $error("on-demand did not engage");
  property p_trip_set;
    (die_temp_in >= TTC_CAT_TEMP) [*3] |-> ##[1:8] !catastrophic_trip_n_out;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip not raised");
  property p_trip_hold;
    !catastrophic_trip_n_out |=> !catastrophic_trip_n_out;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip released");
  property p_shut;
    !catastrophic_trip_n_out [*3] |-> !throttle_active_out;
  endproperty
  a_shut: assert property (p_shut) else $error("active after trip");
endmodule : ttc_mon
bind ttc_throttle_top ttc_mon mon_u (.mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .die_temp_in,
  .clk_stopped_in, .core_clk_en_out, .throttle_active_out, .die_hot_indicator_n_out, .catastrophic_trip_n_out);

// >>> tb/ttc_platform_model.sv
module ttc_platform #(
  parameter int OFF_CYCLES = 16
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic catastrophic_trip_n_in,
  output logic supply_on_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_reg;
  // Cuts the core supply a bounded time after the trip is seen.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 8'h00;
      supply_on_out <= 1'b1;
    end else if (!catastrophic_trip_n_in) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == 8'(OFF_CYCLES)) begin
        supply_on_out <= 1'b0;
      end
    end
  end
endmodule : ttc_platform

// >>> tb/ttc_throttle_top_tb.sv
module ttc_throttle_top_tb
  import ttc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  ttc_bus_req_t bus = '0;
  logic [7:0] temp = 8'h32;
  logic stopped = 1'b0;
  logic [7:0] ratio = 8'h40;
  logic [31:0] rdata;
  logic [7:0] op_pt;
  logic clk_en, active, irq, hot_n, trip_n, supply;
  int miscompares = 0;
  int samples_checked = 0;
  always #12.5 mclk_in = ~mclk_in;
  ttc_throttle_top dut_u (.mclk_in, .rst_n_in, .reg_addr_in(bus.addr), .reg_wdata_in(bus.wdata),
    .reg_wr_in(bus.wr), .reg_rd_in(bus.rd), .reg_rdata_out(rdata), .die_temp_in(temp),
    .clk_stopped_in(stopped), .core_ratio_in(ratio), .op_point_out(op_pt), .core_clk_en_out(clk_en),
    .throttle_active_out(active), .therm_irq_out(irq), .die_hot_indicator_n_out(hot_n),
    .catastrophic_trip_n_out(trip_n));
  ttc_platform plat_u (.mclk_in, .rst_n_in, .catastrophic_trip_n_in(trip_n), .supply_on_out(supply));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask : wait_n
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    @(negedge mclk_in);
    chk(rdata, exp);
  endtask : rd_chk
  task automatic set_env(input logic [7:0] t, input logic s);
    @(posedge mclk_in);
    temp <= t;
    stopped <= s;
    wait_n(20);
  endtask : set_env
  task automatic count_on(input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge mclk_in);
      if (clk_en === 1'b1) c++;
    end
    chk(32'(c), 32'(exp));
  endtask : count_on
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk({24'h0, op_pt}, {24'h0, TTC_OPPT_RST});
    rd_chk(TTC_OFS_GATE_CTRL, {27'h0, TTC_GATE_CTRL_RST});
    rd_chk(TTC_OFS_AUTO_CFG, {16'h0, TTC_AUTO_CFG_RST});
    rd_chk(TTC_OFS_LOAD_REQ, {24'h0, TTC_OPPT_RST});
    rd_chk(TTC_OFS_IDENT, {16'h0, TTC_IDENT_RST});
    wr_reg(4'h9, 32'hFFFF_FFFF);
    rd_chk(4'h9, 32'h0000_0000);
    wr_reg(TTC_OFS_GATE_CTRL, 32'h0000_001F);
    rd_chk(TTC_OFS_GATE_CTRL, 32'h0000_001E);
    wr_reg(TTC_OFS_GATE_CTRL, 32'h0000_0000);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_demand;
    for (int k = 1; k < 8; k++) begin
      wr_reg(TTC_OFS_GATE_CTRL, 32'h0000_0010 | 32'(k << 1));
      wait_n(256);
      count_on(256, k * 32);
    end
    @(posedge mclk_in);
    ratio <= 8'h80;
    wr_reg(TTC_OFS_GATE_CTRL, 32'h0000_0012);
    wait_n(256);
    count_on(128, 16);
    @(posedge mclk_in);
    ratio <= 8'h40;
    wr_reg(TTC_OFS_GATE_CTRL, 32'h0000_0000);
    $display("t_demand done");
  endtask : t_demand
  task automatic t_auto;
    wr_reg(TTC_OFS_AUTO_CFG, 32'h0000_000D);
    wr_reg(TTC_OFS_GATE_CTRL, 32'h0000_0012);
    set_env(8'h63, 1'b0);
    chk({31'h0, hot_n}, 32'h1);
    set_env(8'h70, 1'b0);
    chk({31'h0, hot_n}, 32'h0);
    wait_n(256);
    count_on(256, 128);
    chk({31'h0, irq}, 32'h1);
    set_env(8'h63, 1'b0);
    chk({31'h0, hot_n}, 32'h0);
    wr_reg(TTC_OFS_GATE_CTRL, 32'h0000_0000);
    set_env(8'h50, 1'b0);
    chk({30'h0, active, clk_en}, 32'h1);
    rd_chk(TTC_OFS_EVENTS, 32'h0000_0003);
    wr_reg(TTC_OFS_EVENTS, 32'h0000_0003);
    rd_chk(TTC_OFS_EVENTS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    $display("t_auto done");
  endtask : t_auto
  task automatic t_oppt;
    wr_reg(TTC_OFS_AUTO_CFG, 32'h0000_4003);
    wr_reg(TTC_OFS_LOAD_REQ, 32'h0000_00C0);
    set_env(8'h70, 1'b0);
    chk({24'h0, op_pt}, 32'h40);
    wr_reg(TTC_OFS_LOAD_REQ, 32'h0000_0080);
    wait_n(8);
    chk({24'h0, op_pt}, 32'h40);
    rd_chk(TTC_OFS_STATUS, 32'h0000_0017);
    wr_reg(TTC_OFS_LOAD_REQ, 32'h0000_0020);
    wait_n(8);
    chk({24'h0, op_pt}, 32'h20);
    rd_chk(TTC_OFS_OP_POINT, 32'h0000_0020);
    wr_reg(TTC_OFS_LOAD_REQ, 32'h0000_00A0);
    set_env(8'h50, 1'b0);
    chk({24'h0, op_pt}, 32'hA0);
    wr_reg(TTC_OFS_AUTO_CFG, 32'h0000_0001);
    $display("t_oppt done");
  endtask : t_oppt
  task automatic t_stop;
    set_env(8'h50, 1'b1);
    set_env(8'h70, 1'b1);
    chk({31'h0, hot_n}, 32'h1);
    set_env(8'h70, 1'b0);
    set_env(8'h70, 1'b1);
    set_env(8'h50, 1'b1);
    chk({31'h0, hot_n}, 32'h0);
    set_env(8'h50, 1'b0);
    chk({31'h0, hot_n}, 32'h1);
    $display("t_stop done");
  endtask : t_stop
  task automatic t_trip;
    set_env(8'h7D, 1'b1);
    chk({31'h0, trip_n}, 32'h0);
    set_env(8'h50, 1'b0);
    chk({30'h0, trip_n, active}, 32'h0);
    chk({31'h0, supply}, 32'h0);
    $display("t_trip done");
  endtask : t_trip
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #1_000_000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_demand();
    t_auto();
    t_oppt();
    t_stop();
    t_trip();
    tally_and_finish();
  end
endmodule : ttc_throttle_top_tb
